// ===== logic/timer16_pkg.sv
/*
 * Constants for the 16-bit timer capture, compare and PWM block:
 * register indexes, field positions, reset values and PWM top values.
 * Assumes an APB bus with 32-bit data and one register per word.
 */
package timer16_pkg;
    // Register indexes; the byte address is four times the index
    localparam logic [5:0] IDX_CAP_L = 6'h26;
    localparam logic [5:0] IDX_CAP_H = 6'h27;
    localparam logic [5:0] IDX_CMPB_L = 6'h28;
    localparam logic [5:0] IDX_CMPB_H = 6'h29;
    localparam logic [5:0] IDX_CMPA_L = 6'h2A;
    localparam logic [5:0] IDX_CMPA_H = 6'h2B;
    localparam logic [5:0] IDX_CNT_L = 6'h2C;
    localparam logic [5:0] IDX_CNT_H = 6'h2D;
    localparam logic [5:0] IDX_CTRL_B = 6'h2E;
    localparam logic [5:0] IDX_CTRL_A = 6'h2F;
    localparam logic [5:0] IDX_PIN_CFG = 6'h30;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h31;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h32;
    localparam logic [5:0] IDX_IRQ_EN = 6'h33;

    // Control A fields
    localparam int CA_MODE_A = 6;
    localparam int CA_MODE_B = 4;
    localparam int CA_FORCE_A = 3;
    localparam int CA_FORCE_B = 2;
    localparam int CA_PWM_SEL = 0;
    localparam logic [7:0] CA_STORE_MASK = 8'hF3;

    // Control B fields
    localparam int CB_RUN = 0;
    localparam int CB_CLEAR_ON_MATCH = 1;
    localparam int CB_EDGE_SEL = 2;
    localparam int CB_FAST_PWM = 3;

    // Pin configuration fields
    localparam int PC_DIR_A = 0;
    localparam int PC_DIR_B = 1;
    localparam int PC_PORT_A = 2;
    localparam int PC_PORT_B = 3;

    // Interrupt status bit positions
    localparam int EV_CAPTURE = 0;
    localparam int EV_MATCH_A = 1;
    localparam int EV_MATCH_B = 2;
    localparam int EV_OVERFLOW = 3;

    // Output modes and PWM resolutions
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_CLEAR = 2'h2;
    localparam logic [1:0] MODE_SET = 2'h3;
    localparam logic [1:0] PWM_OFF = 2'h0;
    localparam logic [1:0] PWM_8BIT = 2'h1;
    localparam logic [1:0] PWM_9BIT = 2'h2;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// ===== logic/timer16_capture_compare_pwm.sv
/*
 * 16-bit timer with two compare outputs, forced compare, input capture,
 * phase-correct and fast PWM, shared high-byte latch, interrupt logic.
 * Assumes an APB master, byte data in pwdata[7:0], and a capture input
 * that is already synchronous to clk_sys.
 */
// Decided for this implementation: register access over APB.
// How it works
// - outside PWM a match clears, sets, toggles or leaves each pin.
// - a pin carries the timer output only when its direction is output.
// - force bit A applies channel A action at once like a match.
// - a forced compare sets no flag and never clears the counter.
// - force uses the mode bits held before the same write.
// - both force bits are strobes that read back as zero.
// - in PWM mode force writes change nothing.
// - force bit B does for channel B what force A does.
// - the chosen capture edge copies the counter and sets the flag.
// - capture register is 16 bits, read only, reset to zero.
// - low byte read loads latch with high byte; high read returns latch.
// - one high-byte latch serves counter, both compares and capture.
// - phase-correct PWM counts up to top and back down to zero.
// - PWM compares use the low 8, 9 or 10 compare bits.
// - a fast PWM variant counts up only, twice the rate.
`timescale 1ns/1ns
`default_nettype none

module timer16_capture_compare_pwm
    import timer16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capturePin,
    output logic compareOutA,
    output logic compareOutAOe,
    output logic compareOutB,
    output logic compareOutBOe,
    output logic irq
);

    // Non-PWM output action for one channel
    function automatic logic matchAction(input logic [1:0] mode,
                                         input logic cur);
        logic res;
        res = cur;
        unique case (mode)
            MODE_OFF: res = cur;
            MODE_TOGGLE: res = ~cur;
            MODE_CLEAR: res = 1'b0;
            MODE_SET: res = 1'b1;
        endcase
        return res;
    endfunction

    // PWM output action: mode 10 clears on rising match, 11 inverts
    function automatic logic pwmAction(input logic [1:0] mode,
                                       input logic cur, input logic up);
        logic res;
        res = cur;
        if (mode == MODE_CLEAR) begin
            res = ~up;
        end else if (mode == MODE_SET) begin
            res = up;
        end
        return res;
    endfunction

    logic [7:0] ctrlA_q;
    logic [3:0] ctrlB_q;
    logic [3:0] pinCfg_q;
    logic [3:0] irqStatus_q;
    logic [3:0] irqEnable_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic down_q;
    logic down_d;
    logic [15:0] cmpBufA_q;
    logic [15:0] cmpBufB_q;
    logic [15:0] cmpActA_q;
    logic [15:0] cmpActB_q;
    logic [15:0] capture_q;
    logic [7:0] temp_q;
    logic capPrev_q;
    logic ocA_q;
    logic ocB_q;
    logic ocA_d;
    logic ocB_d;
    logic [31:0] prdata_q;

    // Address decode; only aligned word addresses hit a register
    wire logic [5:0] idx = paddr[7:2];
    wire logic aligned = (paddr[1:0] == 2'h0);
    wire logic hitCapL = aligned && (idx == IDX_CAP_L);
    wire logic hitCapH = aligned && (idx == IDX_CAP_H);
    wire logic hitCmpBL = aligned && (idx == IDX_CMPB_L);
    wire logic hitCmpBH = aligned && (idx == IDX_CMPB_H);
    wire logic hitCmpAL = aligned && (idx == IDX_CMPA_L);
    wire logic hitCmpAH = aligned && (idx == IDX_CMPA_H);
    wire logic hitCntL = aligned && (idx == IDX_CNT_L);
    wire logic hitCntH = aligned && (idx == IDX_CNT_H);
    wire logic hitCtrlB = aligned && (idx == IDX_CTRL_B);
    wire logic hitCtrlA = aligned && (idx == IDX_CTRL_A);
    wire logic hitPinCfg = aligned && (idx == IDX_PIN_CFG);
    wire logic hitStat = aligned && (idx == IDX_IRQ_STAT);
    wire logic hitClr = aligned && (idx == IDX_IRQ_CLR);
    wire logic hitEn = aligned && (idx == IDX_IRQ_EN);
    wire logic mapped = hitCapL || hitCapH || hitCmpBL || hitCmpBH
        || hitCmpAL || hitCmpAH || hitCntL || hitCntH || hitCtrlB
        || hitCtrlA || hitPinCfg || hitStat || hitClr || hitEn;

    // Writes take effect in the access phase; reads are sampled in setup
    // so the latch load and the returned byte come from the same edge
    wire logic wrEn = psel && penable && pwrite && pstrb[0] && mapped;
    wire logic rdEn = psel && !penable && !pwrite;
    wire logic [7:0] wrByte = pwdata[7:0];
    wire logic wrCtrlA = wrEn && hitCtrlA;
    wire logic wrCntL = wrEn && hitCntL;

    // Read data mux; control A force bits are never stored
    wire logic [7:0] rdByte =
        hitCapL ? capture_q[7:0] :
        hitCmpBL ? cmpBufB_q[7:0] :
        hitCmpAL ? cmpBufA_q[7:0] :
        hitCntL ? cnt_q[7:0] :
        (hitCapH || hitCmpBH || hitCmpAH || hitCntH) ? temp_q :
        hitCtrlB ? {4'h0, ctrlB_q} :
        hitCtrlA ? ctrlA_q :
        hitPinCfg ? {4'h0, pinCfg_q} :
        hitStat ? {4'h0, irqStatus_q} :
        hitEn ? {4'h0, irqEnable_q} : RESET_BYTE;
    wire logic rdLow = rdEn && (hitCapL || hitCmpBL || hitCmpAL || hitCntL);
    wire logic [7:0] rdHigh =
        hitCapL ? capture_q[15:8] :
        hitCmpBL ? cmpBufB_q[15:8] :
        hitCmpAL ? cmpBufA_q[15:8] : cnt_q[15:8];
    wire logic wrHigh = wrEn && (hitCmpBH || hitCmpAH || hitCntH);

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // Mode decode, using the settings held before any write this cycle
    wire logic [1:0] pwmSel = ctrlA_q[CA_PWM_SEL +: 2];
    wire logic [1:0] modeA = ctrlA_q[CA_MODE_A +: 2];
    wire logic [1:0] modeB = ctrlA_q[CA_MODE_B +: 2];
    wire logic pwmOn = (pwmSel != PWM_OFF);
    wire logic fastPwm = pwmOn && ctrlB_q[CB_FAST_PWM];
    wire logic run = ctrlB_q[CB_RUN];
    wire logic [15:0] top = (pwmSel == PWM_8BIT) ? TOP_8BIT :
        (pwmSel == PWM_9BIT) ? TOP_9BIT : TOP_10BIT;

    // PWM compares only see the low bits selected by the top value
    wire logic [15:0] cmpA = pwmOn ? (cmpActA_q & top) : cmpActA_q;
    wire logic [15:0] cmpB = pwmOn ? (cmpActB_q & top) : cmpActB_q;
    wire logic matchA = run && !wrCntL && (cnt_q == cmpA);
    wire logic matchB = run && !wrCntL && (cnt_q == cmpB);
    wire logic atTop = pwmOn && (cnt_q >= top);
    wire logic overflow = run && !wrCntL && (pwmOn
        ? (fastPwm ? atTop : (down_q && cnt_q == RESET_WORD))
        : (cnt_q == CNT_MAX));

    // force strobes, ignored in PWM mode
    wire logic forceA = wrCtrlA && wrByte[CA_FORCE_A] && !pwmOn;
    wire logic forceB = wrCtrlA && wrByte[CA_FORCE_B] && !pwmOn;

    // capture edge detect on the synchronous capture input
    wire logic capRise = capturePin && !capPrev_q;
    wire logic capFall = !capturePin && capPrev_q;
    wire logic capEdge = ctrlB_q[CB_EDGE_SEL] ? capRise : capFall;

    // Events for the interrupt status; forced compares never appear here
    // no flag
    wire logic [3:0] events = {overflow, matchB, matchA, capEdge};

    // Counter next state: normal, fast PWM and phase-correct PWM
    always_comb begin
        cnt_d = cnt_q;
        down_d = down_q;
        if (wrCntL) begin
            cnt_d = {temp_q, wrByte};
        end else if (!run) begin
            cnt_d = cnt_q;
        end else if (!pwmOn) begin
            // only a real match clears, never a forced one
            if (ctrlB_q[CB_CLEAR_ON_MATCH] && matchA) begin
                cnt_d = RESET_WORD;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end else if (fastPwm) begin
            cnt_d = atTop ? RESET_WORD : cnt_q + 16'h0001;
            down_d = 1'b0;
        end else if (!down_q) begin
            if (atTop) begin
                down_d = 1'b1;
                cnt_d = cnt_q - 16'h0001;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end else begin
            if (cnt_q == RESET_WORD) begin
                down_d = 1'b0;
                cnt_d = 16'h0001;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end

    // Output latch next state per channel
    always_comb begin
        ocA_d = ocA_q;
        ocB_d = ocB_q;
        if (pwmOn && run) begin
            // phase-correct, mode 10: clear counting up, set counting down; 11 the reverse
            if (matchA) begin
                ocA_d = pwmAction(modeA, ocA_q, fastPwm || !down_q);
            end
            if (matchB) begin
                ocB_d = pwmAction(modeB, ocB_q, fastPwm || !down_q);
            end
            // Fast PWM starts every period in the inactive-match state
            if (fastPwm && atTop && !matchA) begin
                ocA_d = pwmAction(modeA, ocA_q, 1'b0);
            end
            if (fastPwm && atTop && !matchB) begin
                ocB_d = pwmAction(modeB, ocB_q, 1'b0);
            end
        end else if (!pwmOn) begin
            // match or force uses the old mode bits
            if (matchA || forceA) begin
                ocA_d = matchAction(modeA, ocA_q);
            end
            if (matchB || forceB) begin
                ocB_d = matchAction(modeB, ocB_q);
            end
        end
    end

    // Pins: the timer output replaces the port bit when connected
    // direction gates the pin
    wire logic connA = pwmOn ? modeA[1] : (modeA != MODE_OFF);
    wire logic connB = pwmOn ? modeB[1] : (modeB != MODE_OFF);
    assign compareOutA = connA ? ocA_q : pinCfg_q[PC_PORT_A];
    assign compareOutB = connB ? ocB_q : pinCfg_q[PC_PORT_B];
    assign compareOutAOe = pinCfg_q[PC_DIR_A];
    assign compareOutBOe = pinCfg_q[PC_DIR_B];
    assign irq = |(irqStatus_q & irqEnable_q);

    // Compare buffers reload at top in PWM so edges never glitch
    wire logic reload = !pwmOn || (run && (fastPwm ? atTop
        : (!down_q && atTop)));

    // Control, pin and interrupt registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrlA_q <= RESET_BYTE;
            ctrlB_q <= 4'h0;
            pinCfg_q <= 4'h0;
            irqEnable_q <= 4'h0;
            irqStatus_q <= 4'h0;
        end else begin
            if (wrCtrlA) begin
                ctrlA_q <= wrByte & CA_STORE_MASK;
            end
            if (wrEn && hitCtrlB) begin
                ctrlB_q <= wrByte[3:0];
            end
            if (wrEn && hitPinCfg) begin
                pinCfg_q <= wrByte[3:0];
            end
            if (wrEn && hitEn) begin
                irqEnable_q <= wrByte[3:0];
            end
            // A new event wins over a clear in the same cycle
            irqStatus_q <= (irqStatus_q
                & ~((wrEn && hitClr) ? wrByte[3:0] : 4'h0)) | events;
        end
    end

    // Counter, direction and output latches
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= RESET_WORD;
            down_q <= 1'b0;
            ocA_q <= 1'b0;
            ocB_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            down_q <= down_d;
            ocA_q <= ocA_d;
            ocB_q <= ocB_d;
        end
    end

    // Compare registers: buffered write, active copy used by the match
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmpBufA_q <= RESET_WORD;
            cmpBufB_q <= RESET_WORD;
            cmpActA_q <= RESET_WORD;
            cmpActB_q <= RESET_WORD;
        end else begin
            if (wrEn && hitCmpAL) begin
                cmpBufA_q <= {temp_q, wrByte};
            end
            if (wrEn && hitCmpBL) begin
                cmpBufB_q <= {temp_q, wrByte};
            end
            if (reload) begin
                cmpActA_q <= cmpBufA_q;
                cmpActB_q <= cmpBufB_q;
            end
        end
    end

    // Capture register, shared latch and read data
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            capture_q <= RESET_WORD;
            capPrev_q <= 1'b0;
            temp_q <= RESET_BYTE;
            prdata_q <= 32'h00000000;
        end else begin
            capPrev_q <= capturePin;
            if (capEdge) begin
                capture_q <= cnt_q;
            end
            // one latch for every 16-bit register
            if (rdLow) begin
                temp_q <= rdHigh;
            end else if (wrHigh) begin
                temp_q <= wrByte;
            end
            if (rdEn) begin
                prdata_q <= {24'h000000, rdByte};
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_toggle_match: assert property (
        matchA && !pwmOn && modeA == MODE_TOGGLE |=> ocA_q != $past(ocA_q))
        else $error("toggle mode did not toggle on match");
    a_pin_direction: assert property (
        compareOutAOe == pinCfg_q[PC_DIR_A]
        && compareOutBOe == pinCfg_q[PC_DIR_B])
        else $error("pin enable differs from direction bit");
    a_force_old_mode: assert property (
        forceA && modeA == MODE_CLEAR |=> !ocA_q)
        else $error("forced clear did not clear channel A");
    a_force_no_flag: assert property (
        forceA && !matchA && !(wrEn && hitClr) |=> irqStatus_q[EV_MATCH_A]
        == $past(irqStatus_q[EV_MATCH_A]))
        else $error("forced compare changed a flag");
    a_force_reads_zero: assert property (
        rdEn && hitCtrlA |=> !prdata_q[CA_FORCE_A] && !prdata_q[CA_FORCE_B])
        else $error("force bits read back as one");
    a_pwm_force_ignored: assert property (
        wrCtrlA && wrByte[CA_FORCE_A] && pwmOn && !run |=> $stable(ocA_q))
        else $error("force acted in PWM mode");
    a_force_b_set: assert property (
        forceB && modeB == MODE_SET |=> ocB_q)
        else $error("forced set did not set channel B");
    a_capture_copy: assert property (
        capEdge |=> capture_q == $past(cnt_q) && irqStatus_q[EV_CAPTURE])
        else $error("capture value or flag wrong");
    a_temp_latch: assert property (
        rdEn && hitCapL |=> temp_q == $past(capture_q[15:8]))
        else $error("latch not loaded by capture low read");
    a_phase_turn: assert property (
        run && pwmOn && !fastPwm && !down_q && atTop && !wrCntL
        |=> down_q && cnt_q == $past(cnt_q) - 16'h0001)
        else $error("phase-correct counter did not turn at top");

    c_capture: cover property (capEdge ##1 rdEn && hitCapL);
    c_force: cover property (forceA ##[1:20] forceB);
    c_phase_pwm: cover property (pwmOn && down_q && cnt_q == RESET_WORD);
    c_irq: cover property (irq ##1 wrEn && hitClr);

endmodule

`default_nettype wire

// ===== tb/pin_partner.sv
/*
 * Model of the board around the timer pins: it drives the capture input
 * and resolves the two compare pins as wires with a pull-up.
 * Assumes the bench sets capDrive just after a rising edge of clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_partner (
    input wire logic clk_sys,
    input wire logic capDrive,
    output logic capturePin,
    input wire logic outA,
    input wire logic oeA,
    input wire logic outB,
    input wire logic oeB,
    output logic pinA,
    output logic pinB
);
    // Capture source is registered, as a synchroniser on the board would be
    always_ff @(posedge clk_sys) begin
        capturePin <= capDrive;
    end

    // Released pins float up to the pull-up level, never the last value
    assign pinA = oeA ? outA : 1'b1;
    assign pinB = oeB ? outB : 1'b1;
endmodule

`default_nettype wire

// ===== tb/timer16_capture_compare_pwm_bench.sv
/*
 * Self-checking bench for the timer capture, compare and PWM block.
 * Assumes zero wait states are not relied on: every transfer waits for
 * pready, and read results are checked by a monitor from a queue.
 */
`timescale 1ns/1ns
`default_nettype none

module timer16_capture_compare_pwm_bench;
    import timer16_pkg::*;
    logic clk_sys, reset, psel, penable, pwrite, capDrive;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, capturePin, irq, pinA, pinB, snapA;
    logic compareOutA, compareOutAOe, compareOutB, compareOutBOe;
    logic [32:0] expQ[$];
    logic [15:0] cnt;
    int numErrors = 0;
    int checked = 0;
    logic [1:0] modes[8] = '{MODE_SET, MODE_SET, MODE_TOGGLE, MODE_TOGGLE,
        MODE_CLEAR, MODE_OFF, MODE_SET, MODE_TOGGLE};
    logic pinExp[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

    timer16_capture_compare_pwm dut (.clk_sys(clk_sys), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capturePin(capturePin),
        .compareOutA(compareOutA), .compareOutAOe(compareOutAOe),
        .compareOutB(compareOutB), .compareOutBOe(compareOutBOe), .irq(irq));
    pin_partner far (.clk_sys(clk_sys), .capDrive(capDrive),
        .capturePin(capturePin), .outA(compareOutA), .oeA(compareOutAOe),
        .outB(compareOutB), .oeB(compareOutBOe), .pinA(pinA), .pinB(pinB));

    // Free-running system clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; a read notes {pslverr, prdata} for the monitor
    task automatic apb(input logic wr, input logic [5:0] idx,
        input logic [7:0] wd, input logic [7:0] exp, input logic err);
        if (!wr) begin
            expQ.push_back({err, 24'h000000, exp});
        end
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this step
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, exp, 1'b0);
    endtask

    // Bounded wait for the interrupt line, one extra edge to settle
    task automatic wait_irq();
        for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk_sys);
        @(posedge clk_sys);
    endtask

    // Read results are matched against the oldest note at the access edge
    always @(posedge clk_sys) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (expQ.size() == 0) begin
                check(33'h0, 33'h1FFFFFFFF);
            end else begin
                check({pslverr, prdata}, expQ.pop_front());
            end
        end
    end

    // Watchdog sized well above the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        numErrors++;
        finish_test();
    end

    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, capDrive} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        void'($urandom(32'hA4EB));
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // Reset values, read-only capture, strobe readback, unmapped index
        rd(IDX_CAP_L, RESET_BYTE);
        rd(IDX_CAP_H, RESET_BYTE);
        rd(IDX_CTRL_A, RESET_BYTE);
        apb(1'b0, 6'h00, 8'h00, 8'h00, 1'b1);
        wr(IDX_CAP_L, 8'h5A);
        rd(IDX_CAP_L, RESET_BYTE);
        wr(IDX_CTRL_A, 8'hFC);
        rd(IDX_CTRL_A, 8'hF0);
        wr(IDX_CTRL_A, 8'h00);
        $display("register test done");
        // Forced compares in every mode, with counter clear enabled
        wr(IDX_IRQ_EN, 8'h0F);
        wr(IDX_PIN_CFG, 8'h0F);
        wr(IDX_CTRL_B, 8'h02);
        wr(IDX_CNT_H, 8'h00);
        wr(IDX_CNT_L, 8'h42);
        for (int i = 0; i < 8; i++) begin
            // mode written with the strobe acts only from the next one
            wr(IDX_CTRL_A, {modes[i], modes[i], 4'hC});
            @(posedge clk_sys);
            check({32'h0, pinA}, {32'h0, pinExp[i]});
            check({32'h0, pinB}, {32'h0, pinExp[i]});
        end
        rd(IDX_IRQ_STAT, 8'h00);
        check({32'h0, irq}, 33'h0);
        rd(IDX_CNT_L, 8'h42);
        rd(IDX_CNT_H, 8'h00);
        // Direction input: pin released and pulled up
        wr(IDX_PIN_CFG, 8'h00);
        wr(IDX_CTRL_A, {MODE_CLEAR, MODE_CLEAR, 4'hC});
        @(posedge clk_sys);
        check({31'h0, compareOutAOe, compareOutBOe}, 33'h0);
        check({32'h0, pinA}, 33'h1);
        // Strobes in PWM mode leave pin and flags alone
        wr(IDX_PIN_CFG, 8'h03);
        wr(IDX_CTRL_A, {MODE_SET, MODE_SET, 2'b00, PWM_8BIT});
        @(posedge clk_sys);
        snapA = pinA;
        wr(IDX_CTRL_A, {MODE_TOGGLE, MODE_TOGGLE, 2'b11, PWM_8BIT});
        @(posedge clk_sys);
        check({32'h0, pinA}, {32'h0, snapA});
        rd(IDX_CTRL_A, {MODE_TOGGLE, MODE_TOGGLE, 2'b00, PWM_8BIT});
        rd(IDX_IRQ_STAT, 8'h00);
        $display("force test done");
        // Capture on rising then falling edge, mask and clear the flag
        wr(IDX_CTRL_A, 8'h00);
        for (int e = 1; e >= 0; e--) begin
            cnt = 16'($urandom());
            wr(IDX_CTRL_B, 8'(e << CB_EDGE_SEL));
            wr(IDX_CNT_H, cnt[15:8]);
            wr(IDX_CNT_L, cnt[7:0]);
            wr(IDX_IRQ_EN, 8'h01);
            capDrive <= e[0];
            wait_irq();
            check({32'h0, irq}, 33'h1);
            // low byte first, no competing latch user
            rd(IDX_CAP_L, cnt[7:0]);
            rd(IDX_CAP_H, cnt[15:8]);
            wr(IDX_IRQ_EN, 8'h00);
            @(posedge clk_sys);
            check({32'h0, irq}, 33'h0);
            rd(IDX_IRQ_STAT, 8'h01);
            wr(IDX_IRQ_CLR, 8'h01);
            rd(IDX_IRQ_STAT, 8'h00);
        end
        // Latch is shared: a counter high write shows in capture high
        rd(IDX_CAP_L, cnt[7:0]);
        wr(IDX_CNT_H, 8'h5A);
        rd(IDX_CAP_H, 8'h5A);
        $display("capture test done");
        // Real match on channel A toggles the pin and raises the flag
        wr(IDX_CTRL_B, 8'h00);
        wr(IDX_CTRL_A, {MODE_SET, MODE_SET, 4'h0});
        wr(IDX_CTRL_A, {MODE_SET, MODE_SET, 4'hC});
        wr(IDX_CTRL_A, {MODE_TOGGLE, MODE_TOGGLE, 4'h0});
        wr(IDX_CNT_H, 8'h00);
        wr(IDX_CNT_L, 8'h00);
        wr(IDX_CMPA_H, 8'h00);
        wr(IDX_CMPA_L, 8'h20);
        wr(IDX_IRQ_CLR, 8'h0F);
        wr(IDX_IRQ_EN, 8'h02);
        wr(IDX_CTRL_B, 8'h01);
        wait_irq();
        check({32'h0, irq}, 33'h1);
        check({32'h0, pinA}, 33'h0);
        wr(IDX_CTRL_B, 8'h00);
        $display("match test done");
        finish_test();
    end
endmodule

`default_nettype wire
